//--- inc/adcx_map.svh
// Register indices, field positions, reset values and timing counts.
`ifndef ADCX_MAP_SVH
`define ADCX_MAP_SVH
// Register indices; the byte address is four times the index.
`define ADCX_IDX_PIN_OFF0   6'h01
`define ADCX_IDX_PIN_OFF1   6'h02
`define ADCX_IDX_CTRL_B     6'h03
`define ADCX_IDX_RES_LOW    6'h04
`define ADCX_IDX_RES_HIGH   6'h05
`define ADCX_IDX_CTRL_A     6'h06
`define ADCX_IDX_CH_REF     6'h07
// Control register A fields.
`define ADCX_A_ENABLE       7
`define ADCX_A_START        6
`define ADCX_A_AUTO_EN      5
`define ADCX_A_FLAG         4
`define ADCX_A_IRQ_EN       3
// Control register B fields.
`define ADCX_B_BIPOLAR      7
`define ADCX_B_GAIN_BOOST   6
`define ADCX_B_REF_HI       4
`define ADCX_B_CH_MSB       3
`define ADCX_B_WMASK        8'hdf
// Channel and reference register fields.
`define ADCX_M_LEFT         5
// Reset value of every register.
`define ADCX_REG_RESET      8'h00
// Conversion lengths in converter clock ticks.
`define ADCX_CONV_TICKS     5'h0d
`define ADCX_FIRST_TICKS    5'h19
// Result limits.
`define ADCX_UNI_MAX        11'sh3ff
`define ADCX_BIP_MAX        11'sh1ff
`define ADCX_BIP_MIN        -11'sh200
// Bus response codes.
`define ADCX_RESP_OKAY      2'b00
`define ADCX_RESP_SLVERR    2'b10
`endif

//--- inc/adcx_pkg.sv
// Types shared by the converter control block.
package adcx_pkg;
  // Conversion sequencer states.
  typedef enum logic [1:0] {
    CS_IDLE  = 2'b00,
    CS_FIRST = 2'b01,
    CS_RUN   = 2'b10
  } adcx_conv_state_type;
endpackage

//--- rtl/adcx_conv.sv
// Converter clock prescaler and conversion sequencer.
`timescale 1ns/1ps
`include "adcx_map.svh"
module adcx_conv
  import adcx_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  // Control.
  input  wire logic       enable,
  input  wire logic       start,
  input  wire logic [2:0] div_sel,
  // Status.
  output logic            busy,
  output logic            done
);

  // Terminal count of the prescaler for a given select code.
  function automatic logic [6:0] div_last(input logic [2:0] sel);
    case (sel)
      3'h0, 3'h1: div_last = 7'h01;
      3'h2:       div_last = 7'h03;
      3'h3:       div_last = 7'h07;
      3'h4:       div_last = 7'h0f;
      3'h5:       div_last = 7'h1f;
      3'h6:       div_last = 7'h3f;
      default:    div_last = 7'h7f;
    endcase
  endfunction

  logic [6:0]          pre_q;    // Prescaler count.
  logic                tick;     // One converter clock period elapsed.
  logic [4:0]          cnt_q;    // Ticks left in this conversion.
  logic                init_q;   // Set once the first long conversion ran.
  adcx_conv_state_type state_q;  // Sequencer state.

  assign tick = (pre_q >= div_last(div_sel));

  // The prescaler runs only while the converter is enabled.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 7'h00;
    end else if (ce) begin
      if (!enable || tick) begin
        pre_q <= 7'h00; // [RULE1]
      end else begin
        pre_q <= pre_q + 7'h01;
      end
    end
  end

  // Sequencer: the first conversion after enable is the long one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= CS_IDLE;
      cnt_q   <= 5'h00;
      init_q  <= 1'b0;
      done    <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (!enable) begin
        // Turning the converter off aborts any conversion.
        state_q <= CS_IDLE;
        init_q  <= 1'b0;
      end else begin
        case (state_q)
          CS_IDLE: begin
            if (start) begin
              state_q <= init_q ? CS_RUN : CS_FIRST;
              cnt_q   <= init_q ? `ADCX_CONV_TICKS : `ADCX_FIRST_TICKS;
            end
          end
          CS_FIRST, CS_RUN: begin
            if (tick) begin
              if (cnt_q == 5'h01) begin
                state_q <= CS_IDLE;
                init_q  <= 1'b1;
                done    <= 1'b1;
              end else begin
                cnt_q <= cnt_q - 5'h01;
              end
            end
          end
          default: state_q <= CS_IDLE;
        endcase
      end
    end
  end

  assign busy = (state_q != CS_IDLE);

endmodule

//--- rtl/adcx_ctrl.sv
// Converter control block with its AXI4-Lite register slave.
//
// Behaviour
// (RULE1) Prescaler select divides clock 2..128.
// (RULE2) Completed result goes to low/high pair.
// (RULE3) Low-byte read locks pair until high read.
// (RULE4) Software reads low byte before high byte.
// (RULE5) Left align: bits 9..2 high, 1..0 low.
// (RULE6) Right align: bits 7..0 low, 9..8 high.
// (RULE7) Unipolar ten bits, negative input saturates.
// (RULE8) Bipolar gives two's complement nine plus sign.
// (RULE9) Gain boost picks 32x and 8x.
// (RULE10) Reference high bit helps pick internal reference.
// (RULE11) Control B bit five reads zero.
// (RULE12) Channel MSB change waits for conversion end.
// (RULE13) Trigger source ignored unless auto trigger enabled.
// (RULE14) Rising edge of selected source starts conversion.
// (RULE15) Selecting free running causes no trigger.
// (RULE16) Trigger source code decodes to eight sources.
// (RULE17) Input-off bit disables buffer, readback zero.
// (RULE18) Register 0 serves channels 6..0 and reference.
// (RULE19) Register 1 bits 7..4 serve channels 10..7.
// (RULE20) Software disables unused digital inputs on analog pins.
// (RULE21) Complete flag set when conversion finishes.
// (RULE22) Flag cleared by vector taken or writing one.
// (RULE23) Locked result is not overwritten by conversions.
`timescale 1ns/1ps
`include "adcx_map.svh"
module adcx_ctrl
  import adcx_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // AXI4-Lite write address and data.
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // AXI4-Lite write response.
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // AXI4-Lite read.
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [7:0]        s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // Analog front end: signed difference code, and settings.
  input  wire logic signed [10:0] sample_code,
  output logic [5:0]             channel_select,
  output logic                   gain_boost_select,
  output logic                   bipolar_input_select,
  output logic [1:0]             reference_select_lo,
  output logic                   reference_select_hi,
  output logic                   converter_busy,
  // Trigger source flags, index 1..7; bit 0 unused.
  input  wire logic [7:0]        trigger_flags,
  // Interrupt request and vector-taken acknowledge.
  output logic                   conv_complete_irq,
  input  wire logic              conv_complete_ack,
  // Pins: 10..0 analog channels, 11 reference pin.
  input  wire logic [11:0]       pin_level,
  output logic [11:0]            input_buffer_off,
  output logic [11:0]            pin_readback
);

  // Registers written by software.
  logic [7:0]  pin_off0_q;        // Input disable register 0.
  logic [7:0]  pin_off1_q;        // Input disable register 1.
  logic [7:0]  ctrl_b_q;          // Control register B.
  logic [7:0]  ch_ref_q;          // Channel and reference select.
  logic        enable_q;          // Converter enable.
  logic        auto_en_q;         // Auto trigger enable.
  logic        irq_en_q;          // Complete interrupt enable.
  logic [2:0]  div_sel_q;         // Prescaler select.
  logic        flag_q;            // Conversion complete flag.
  // Result and lock.
  logic [9:0]  result_q;          // Stored conversion result.
  logic        lock_q;            // Pair locked after low-byte read.
  logic        ch_msb_q;          // Channel MSB applied to the mux.
  // Trigger.
  logic        trig_prev_q;       // Selected source, previous cycle.
  logic        trig_sel;          // Selected source now.
  logic        start_q;           // Start request to the sequencer.
  // Sequencer.
  logic        busy;
  logic        done;
  // Bus.
  logic        aw_held_q;
  logic        w_held_q;
  logic [5:0]  aw_idx_q;
  logic [7:0]  wbyte_q;
  logic        wen_q;
  logic        wr_go;
  logic        rd_go;
  logic [5:0]  ar_idx;
  logic        sw_start;
  logic        sw_flag_clr;
  logic [9:0]  conv_value;
  logic [11:0] off_vec;

  // Read value of a register index; unmapped ones read zero.
  function automatic logic [7:0] rd_byte(input logic [5:0] idx);
    case (idx)
      `ADCX_IDX_PIN_OFF0: rd_byte = pin_off0_q;
      `ADCX_IDX_PIN_OFF1: rd_byte = pin_off1_q;
      `ADCX_IDX_CTRL_B:   rd_byte = ctrl_b_q & `ADCX_B_WMASK; // [RULE11]
      `ADCX_IDX_RES_LOW:  rd_byte = ch_ref_q[`ADCX_M_LEFT]
                                    ? {result_q[1:0], 6'h00} // [RULE5]
                                    : result_q[7:0];          // [RULE6]
      `ADCX_IDX_RES_HIGH: rd_byte = ch_ref_q[`ADCX_M_LEFT]
                                    ? result_q[9:2]          // [RULE5]
                                    : {6'h00, result_q[9:8]}; // [RULE6]
      `ADCX_IDX_CTRL_A:   rd_byte = {enable_q, busy, auto_en_q, flag_q,
                                     irq_en_q, div_sel_q};
      `ADCX_IDX_CH_REF:   rd_byte = ch_ref_q;
      default:            rd_byte = 8'h00;
    endcase
  endfunction

  // True for an aligned byte address whose index holds a register.
  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr[1:0] == 2'b00) &&
             (addr[7:2] >= `ADCX_IDX_PIN_OFF0) &&
             (addr[7:2] <= `ADCX_IDX_CH_REF);
  endfunction

  assign wr_go  = aw_held_q && w_held_q && !s_axi_bvalid;
  assign rd_go  = s_axi_arvalid && s_axi_arready;
  assign ar_idx = s_axi_araddr[7:2];
  assign sw_start = wr_go && wen_q && (aw_idx_q == `ADCX_IDX_CTRL_A) &&
                    wbyte_q[`ADCX_A_START] && wbyte_q[`ADCX_A_ENABLE];
  assign sw_flag_clr = wr_go && wen_q && (aw_idx_q == `ADCX_IDX_CTRL_A) &&
                       wbyte_q[`ADCX_A_FLAG];

  // Write address and data are taken in either order and held.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_idx_q      <= 6'h00;
      wbyte_q       <= `ADCX_REG_RESET;
      wen_q         <= 1'b0;
    end else if (ce) begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q     <= 1'b1;
        s_axi_awready <= 1'b0;
        // Unmapped addresses get an index no register answers to.
        aw_idx_q      <= mapped(s_axi_awaddr) ? s_axi_awaddr[7:2] : 6'h00;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q     <= 1'b1;
        s_axi_wready <= 1'b0;
        wbyte_q      <= s_axi_wdata[7:0];
        wen_q        <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end
    end
  end

  // Write response; an unmapped address answers with a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ADCX_RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_idx_q == 6'h00) ? `ADCX_RESP_SLVERR
                                            : `ADCX_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one read in flight, data one cycle after the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ADCX_RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000,
                          mapped(s_axi_araddr) ? rd_byte(ar_idx) : 8'h00};
        s_axi_rresp   <= mapped(s_axi_araddr) ? `ADCX_RESP_OKAY
                                              : `ADCX_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Software-written configuration registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_off0_q <= `ADCX_REG_RESET;
      pin_off1_q <= `ADCX_REG_RESET;
      ctrl_b_q   <= `ADCX_REG_RESET;
      ch_ref_q   <= `ADCX_REG_RESET;
      enable_q   <= 1'b0;
      auto_en_q  <= 1'b0;
      irq_en_q   <= 1'b0;
      div_sel_q  <= 3'h0;
    end else if (ce && wr_go && wen_q) begin
      case (aw_idx_q)
        `ADCX_IDX_PIN_OFF0: pin_off0_q <= wbyte_q;
        `ADCX_IDX_PIN_OFF1: pin_off1_q <= wbyte_q;
        `ADCX_IDX_CTRL_B:   ctrl_b_q   <= wbyte_q & `ADCX_B_WMASK;
        `ADCX_IDX_CH_REF:   ch_ref_q   <= wbyte_q;
        `ADCX_IDX_CTRL_A: begin
          enable_q  <= wbyte_q[`ADCX_A_ENABLE];
          auto_en_q <= wbyte_q[`ADCX_A_AUTO_EN];
          irq_en_q  <= wbyte_q[`ADCX_A_IRQ_EN];
          div_sel_q <= wbyte_q[2:0]; // [RULE1]
        end
        default: ;
      endcase
    end
  end

  // Source selection; code 0 selects nothing so no edge appears.
  always_comb begin
    trig_sel = 1'b0;
    if (ctrl_b_q[2:0] != 3'h0) begin
      trig_sel = trigger_flags[ctrl_b_q[2:0]]; // [RULE16] [RULE15]
    end
  end

  // Start requests: software start, source edge or free-run restart.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_prev_q <= 1'b0;
      start_q     <= 1'b0;
    end else if (ce) begin
      trig_prev_q <= trig_sel;
      start_q     <= 1'b0;
      if (sw_start) begin
        start_q <= 1'b1;
      end else if (enable_q && auto_en_q) begin // [RULE13]
        if (trig_sel && !trig_prev_q) begin
          start_q <= 1'b1; // [RULE14]
        end else if (ctrl_b_q[2:0] == 3'h0 && done) begin
          start_q <= 1'b1;
        end
      end
    end
  end

  // Prescaler and conversion timing.
  adcx_conv adcx_conv_inst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .enable  (enable_q),
    .start   (start_q),
    .div_sel (div_sel_q),
    .busy    (busy),
    .done    (done)
  );

  // Format the front end code by mode.
  always_comb begin
    if (ctrl_b_q[`ADCX_B_BIPOLAR]) begin
      if (sample_code > `ADCX_BIP_MAX) begin
        conv_value = 10'h1ff; // [RULE8]
      end else if (sample_code < `ADCX_BIP_MIN) begin
        conv_value = 10'h200; // [RULE8]
      end else begin
        conv_value = sample_code[9:0]; // [RULE8]
      end
    end else if (sample_code < 11'sh000) begin
      conv_value = 10'h3ff; // [RULE7]
    end else if (sample_code > `ADCX_UNI_MAX) begin
      conv_value = 10'h3ff; // [RULE7]
    end else begin
      conv_value = sample_code[9:0]; // [RULE7]
    end
  end

  // Result store and read lock.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= 10'h000;
      lock_q   <= 1'b0;
    end else if (ce) begin
      if (done && !lock_q) begin
        result_q <= conv_value; // [RULE2] [RULE23]
      end
      if (rd_go && mapped(s_axi_araddr)) begin
        if (ar_idx == `ADCX_IDX_RES_LOW) begin
          lock_q <= 1'b1; // [RULE3] [RULE4]
        end else if (ar_idx == `ADCX_IDX_RES_HIGH) begin
          lock_q <= 1'b0; // [RULE23]
        end
      end
    end
  end

  // Complete flag; a set in the same cycle as a clear wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (ce) begin
      if (done) begin
        flag_q <= 1'b1; // [RULE21]
      end else if (sw_flag_clr || conv_complete_ack) begin
        flag_q <= 1'b0; // [RULE22]
      end
    end
  end

  // Channel MSB follows the register only between conversions.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch_msb_q <= 1'b0;
    end else if (ce && !busy) begin
      ch_msb_q <= ctrl_b_q[`ADCX_B_CH_MSB]; // [RULE12]
    end
  end

  // Which pins have their digital buffers turned off.
  assign off_vec = {pin_off0_q[3],                     // [RULE18]
                    pin_off1_q[7:4],                   // [RULE19]
                    pin_off0_q[7:4], pin_off0_q[2:0]}; // [RULE18]

  // Registered outputs to the front end, pins and interrupt logic.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_select       <= 6'h00;
      gain_boost_select    <= 1'b0;
      bipolar_input_select <= 1'b0;
      reference_select_lo  <= 2'h0;
      reference_select_hi  <= 1'b0;
      converter_busy       <= 1'b0;
      conv_complete_irq    <= 1'b0;
      input_buffer_off     <= 12'h000;
      pin_readback         <= 12'h000;
    end else if (ce) begin
      channel_select       <= {ch_msb_q, ch_ref_q[4:0]};
      gain_boost_select    <= ctrl_b_q[`ADCX_B_GAIN_BOOST]; // [RULE9]
      bipolar_input_select <= ctrl_b_q[`ADCX_B_BIPOLAR];
      reference_select_lo  <= ch_ref_q[7:6];
      reference_select_hi  <= ctrl_b_q[`ADCX_B_REF_HI]; // [RULE10]
      converter_busy       <= busy;
      conv_complete_irq    <= flag_q && irq_en_q;
      input_buffer_off     <= off_vec; // [RULE17]
      pin_readback         <= pin_level & ~off_vec; // [RULE17]
    end
  end

endmodule

//--- test/adcx_ctrl_monitor.sv
// Port assertions for the converter control block.
`timescale 1ns/1ps
`include "adcx_map.svh"
module adcx_ctrl_monitor
  import adcx_pkg::*;
(
  // Clock, reset and enable.
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  // Register bus.
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // Pins and status.
  input wire logic [11:0] pin_level,
  input wire logic [11:0] input_buffer_off,
  input wire logic [11:0] pin_readback,
  input wire logic        conv_complete_irq
);
  // Checks sample on the rising edge and rest during reset or freeze.
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
  a_bvalid_blocks: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read data not on time");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_rdata_upper: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_reserved_zero: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h0c |=>
    s_axi_rdata[5] == 1'b0)
    else $error("reserved control bit read as one");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 8'h40 |=> s_axi_rresp == `ADCX_RESP_SLVERR &&
    s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_readback_off: assert property (
    (pin_readback & input_buffer_off & $past(input_buffer_off)) == 12'h0)
    else $error("disabled pin reads as one");
  a_readback_pass: assert property (
    $past(aresetn) && $stable(pin_level) && $stable(input_buffer_off) |->
    pin_readback == (pin_level & ~input_buffer_off))
    else $error("pin readback wrong");

  // Main scenarios reached.
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_irq: cover property (conv_complete_irq);
endmodule

bind adcx_ctrl adcx_ctrl_monitor adcx_ctrl_monitor_inst (
  .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pin_level,
  .input_buffer_off, .pin_readback, .conv_complete_irq
);

//--- test/adcx_ctrl_test.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`include "adcx_map.svh"
module adcx_ctrl_test
  import adcx_pkg::*;
();
  // Bench-driven inputs, all defined at time zero.
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, conv_complete_ack = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, trigger_flags = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic signed [10:0] sample_code = 11'sh0;
  logic [11:0] pin_level = 12'h0;
  // Design outputs.
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, gain_boost_select, bipolar_input_select;
  logic reference_select_hi, converter_busy, conv_complete_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, reference_select_lo;
  logic [31:0] s_axi_rdata;
  logic [5:0] channel_select;
  logic [11:0] input_buffer_off, pin_readback;
  // Expected answers and tallies.
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int fail_count = 0, compares = 0, n;
  logic [9:0] r;
  logic [7:0] d0, d1;
  logic [11:0] ov;

  adcx_ctrl adcx_ctrl_inst (.*);

  // Free-running 250 MHz clock.
  always #2 aclk = ~aclk;

  // Compares one value and reports a mismatch.
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Writes one register word and notes the expected response.
  task automatic wr(input logic [5:0] a, input logic [7:0] d,
                    input logic [1:0] e = 2'b00);
    logic pa, pw;
    @(posedge aclk);
    pa = 1'b1;
    pw = 1'b1;
    bq.push_back(e);
    s_axi_awaddr <= {a, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      if (s_axi_awready) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  // Reads one register word and notes the expected answer.
  task automatic rd(input logic [5:0] a, input logic [7:0] x,
                    input logic [1:0] e = 2'b00);
    @(posedge aclk);
    rq.push_back({e, 24'h0, x});
    s_axi_araddr <= {a, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // Counts cycles until the busy output reaches a level.
  task automatic till(input logic lvl, input int lim);
    n = 0;
    while (converter_busy !== lvl && n < lim) begin
      @(posedge aclk);
      n++;
    end
  endtask

  // Runs a first conversion and checks length, flag and result layout.
  task automatic conv(input logic [2:0] c, input logic al, input logic bp);
    logic signed [10:0] s;
    int dv;
    s = 11'($urandom_range(0, 2047));
    dv = (c == 3'd0) ? 2 : (1 << c);
    if (bp)
      r = (s > 511) ? 10'h1ff : (s < -512) ? 10'h200 : s[9:0];
    else
      r = (s < 0) ? 10'h3ff : s[9:0];
    sample_code <= s;
    wr(`ADCX_IDX_CTRL_A, 8'h10);
    wr(`ADCX_IDX_CH_REF, {2'b00, al, 5'h00});
    wr(`ADCX_IDX_CTRL_B, {bp, 7'h00});
    wr(`ADCX_IDX_CTRL_A, {5'b11000, c});
    chk(bipolar_input_select, bp);
    till(1'b1, 8);
    till(1'b0, 4000);
    chk(n >= 25 * dv - 2 && n <= 26 * dv + 4, 1);
    repeat (2) @(posedge aclk);
    rd(`ADCX_IDX_CTRL_A, {5'b10010, c});
    rd(`ADCX_IDX_RES_LOW, al ? {r[1:0], 6'h0} : r[7:0]);
    rd(`ADCX_IDX_RES_HIGH, al ? r[9:2] : {6'h0, r[9:8]});
  endtask

  // Ends the run with the tallies and the verdict.
  task automatic give_verdict();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (80000) @(posedge aclk);
    fail_count++;
    give_verdict();
  end

  // Checks bus answers in the order they were requested.
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      chk(s_axi_bresp, bq.pop_front());
  end

  // Main sequence.
  initial begin
    void'($urandom(32'hb892));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, then an unmapped place.
    for (int i = 1; i < 8; i++)
      rd(6'(i), 8'h00);
    wr(6'h10, 8'h55, `ADCX_RESP_SLVERR);
    rd(6'h10, 8'h00, `ADCX_RESP_SLVERR);
    // Input buffer switches and pin readback.
    repeat (4) begin
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      pin_level <= 12'($urandom);
      ov = {d0[3], d1[7:4], d0[7:4], d0[2:0]};
      wr(`ADCX_IDX_PIN_OFF0, d0);
      wr(`ADCX_IDX_PIN_OFF1, d1);
      repeat (2) @(posedge aclk);
      chk(input_buffer_off, ov);
      chk(pin_readback, pin_level & ~ov);
    end
    // Control B fields and the reserved bit.
    wr(`ADCX_IDX_CTRL_B, 8'hff);
    rd(`ADCX_IDX_CTRL_B, 8'hdf);
    chk({gain_boost_select, reference_select_hi}, 2'b11);
    chk({channel_select, reference_select_lo}, 8'h80);
    // Every prescaler code, both alignments and both formats.
    for (int c = 0; c < 8; c++)
      conv(3'(c), c[0], c[1]);
    // Lock on low-byte read; deferred channel MSB.
    conv(3'd0, 1'b0, 1'b0);
    rd(`ADCX_IDX_RES_LOW, r[7:0]);
    sample_code <= ~sample_code;
    wr(`ADCX_IDX_CTRL_A, 8'hc0);
    till(1'b1, 8);
    wr(`ADCX_IDX_CTRL_B, 8'h08);
    chk(channel_select[5], 1'b0);
    till(1'b0, 400);
    repeat (2) @(posedge aclk);
    chk(channel_select[5], 1'b1);
    rd(`ADCX_IDX_RES_HIGH, {6'h0, r[9:8]});
    rd(`ADCX_IDX_RES_LOW, r[7:0]);
    rd(`ADCX_IDX_RES_HIGH, {6'h0, r[9:8]});
    // Trigger flags ignored while auto trigger is off.
    wr(`ADCX_IDX_CTRL_B, 8'h01);
    trigger_flags <= 8'hfe;
    till(1'b1, 10);
    chk(converter_busy, 1'b0);
    trigger_flags <= 8'h00;
    wr(`ADCX_IDX_CTRL_A, 8'ha8);
    // Each source starts only on its own rising edge.
    for (int s = 1; s < 8; s++) begin
      conv_complete_ack <= 1'b1;
      @(posedge aclk);
      conv_complete_ack <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(conv_complete_irq, 1'b0);
      wr(`ADCX_IDX_CTRL_B, 8'(s));
      trigger_flags <= 8'hfe & ~(8'h01 << s);
      till(1'b1, 10);
      chk(converter_busy, 1'b0);
      trigger_flags <= 8'h01 << s;
      till(1'b1, 10);
      chk(converter_busy, 1'b1);
      till(1'b0, 400);
      trigger_flags <= 8'h00;
      repeat (2) @(posedge aclk);
      chk(conv_complete_irq, 1'b1);
    end
    // Free running selected with the flag set starts nothing.
    wr(`ADCX_IDX_CTRL_B, 8'h00);
    till(1'b1, 10);
    chk(converter_busy, 1'b0);
    give_verdict();
  end
endmodule
